// [rtl/bds_pkg.sv]
// Purpose: Shared constants and types for the boot diagnostic sequencer
// Assumes: 200 MHz system clock
// Notes:   Times are kept in their own units; cycle counts derive from them

package bds_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned SETUP_DIAG_MS = 600;
  localparam int unsigned STATUS_SIGNAL_MS = 1600;
  localparam int unsigned SIG_PHASE_MS = 200;
  localparam int unsigned SIG_TAIL_MS = 1000;
  localparam int unsigned DRV_SETTLE_US = 100;
  localparam int unsigned WDT_MS = 100;
  localparam int unsigned SETUP_DIAG_CYC = SETUP_DIAG_MS * CYC_PER_MS;
  localparam int unsigned SIG_PHASE_CYC = SIG_PHASE_MS * CYC_PER_MS;
  localparam int unsigned SIG_TAIL_CYC = SIG_TAIL_MS * CYC_PER_MS;
  localparam int unsigned DRV_SETTLE_CYC = DRV_SETTLE_US * CYC_PER_US;
  localparam int unsigned WDT_CYC = WDT_MS * CYC_PER_MS;
  localparam int unsigned TMR_W = 28;

  // ==========================================================
  // Nonvolatile map
  localparam logic [7:0] NV_ADDR_FACTORY_FIRST = 8'h00;
  localparam logic [7:0] NV_ADDR_FACTORY_LAST = 8'h05;
  localparam logic [7:0] NV_ADDR_GAIN = 8'h06;
  localparam logic [7:0] NV_ADDR_CODE_LAST = 8'h0b;
  localparam logic [7:0] NV_ADDR_CRC = 8'h0c;
  localparam logic [7:0] NV_ADDR_LOGIC_FAIL = 8'hfd;
  localparam logic [7:0] NV_ADDR_OUT_FAIL = 8'hfe;
  localparam logic [7:0] NV_ADDR_SENS_FAIL = 8'hff;
  localparam logic [7:0] FAIL_MARK = 8'ha5;

  // ==========================================================
  // Checksum
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // ==========================================================
  // Test shapes and thresholds
  localparam int unsigned FB_W = 10;
  localparam int unsigned AVG_LOG2 = 4;
  localparam int unsigned FB_FS_MV = 30000;
  localparam int unsigned FB_OFF_MV = 1500;
  localparam int unsigned FB_ON_MV = 7500;
  localparam int unsigned FB_OFF_CODE = FB_OFF_MV * ((1 << FB_W) - 1) / FB_FS_MV;
  localparam int unsigned FB_ON_CODE = FB_ON_MV * ((1 << FB_W) - 1) / FB_FS_MV;
  localparam int unsigned DRV_STEPS = 3;
  localparam int unsigned SIG_PHASES = 4;
  localparam int unsigned SENS_STEPS = 3;
  localparam int unsigned FAIL_LOGIC = 0;
  localparam int unsigned FAIL_OUT = 1;
  localparam int unsigned FAIL_SENS = 2;

  typedef enum logic [3:0] {
    ST_RESTART, ST_RD, ST_DRV_SET, ST_DRV_SETTLE, ST_DRV_AVG, ST_SENS_SET,
    ST_SENS_WAIT, ST_CHECK, ST_SETUP_WAIT, ST_SIG, ST_OPER, ST_FAIL_WR, ST_HALT
  } bds_state_e;

  // One byte through the CRC-8, MSB first
  function automatic logic [7:0] bds_crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : bds_crc8

endpackage : bds_pkg

// [rtl/bds_avg.sv]
// Purpose: Averages a burst of feedback samples
// Assumes: One sample per asserted smp_valid
// Notes:   Mean is the sum shifted right, no rounding

`timescale 1ns/1ps
`default_nettype none

module bds_avg
  import bds_pkg::*;
#(
  parameter int unsigned W = FB_W,
  parameter int unsigned LOG2 = AVG_LOG2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  output logic done,
  // Samples
  input wire logic smp_valid,
  input wire logic [W-1:0] smp,
  output logic [W-1:0] mean
);

  logic busy_q;
  logic [LOG2-1:0] cnt_q;
  logic [W+LOG2-1:0] acc_q;

  // ==========================================================
  // Accumulate and divide
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
      acc_q <= '0;
      done <= 1'b0;
      mean <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy_q <= 1'b1;
        cnt_q <= '0;
        acc_q <= '0;
      end else if (busy_q && smp_valid) begin
        cnt_q <= cnt_q + 1'b1;
        acc_q <= acc_q + (W + LOG2)'(smp);
        if (&cnt_q) begin
          busy_q <= 1'b0;
          done <= 1'b1;
          mean <= W'((acc_q + (W + LOG2)'(smp)) >> LOG2);
        end
      end
    end
  end

endmodule : bds_avg

`default_nettype wire

// [rtl/bds_top.sv]
// Purpose: Power-up self-test and status signalling of the switched output
// Assumes: Nonvolatile memory answers with a one-cycle ack per request
// Notes:   Long counts are parameters so that simulation can shorten them
//
// What this block does
// - Each boot enters diagnosis; output only signals status for 2.2 s.
// - First 600 ms run setup and checks; output toggles there mean nothing.
// - Pass pattern is ON, OFF, ON of 200 ms each, then 1 s OFF.
// - Pattern finished without failure switches into operational mode.
// - Any failure holds output OFF and never enters operational mode.
// - On failure halt and write FAIL_MARK at 0xFD, 0xFE, 0xFF for the failed tests only.
// - Map: factory 0x00-0x05, gain 0x06, constant 0x07-0x0B, checksum 0x0C.
// - Checksum is CRC-8, CCITT polynomial, over gain then five constant bytes.
// - Boot recomputes CRC, compares stored value; mismatch is logic failure.
// - Watchdog in operation restarts the whole diagnostic sequence on a stall.
// - Output test commands driver OFF, ON, OFF over its control line.
// - Each step averages 16 feedback samples; OFF below 1.5 V, ON above 7.5 V.
// - Output stage passes only if every step matched; else output failure.
// - Gain sweep of the optical front end; unexpected response is sensor failure.
// - Setup and diagnostic interval lies in 590 to 610 ms, 600 nominal.

`timescale 1ns/1ps
`default_nettype none

module bds_top
  import bds_pkg::*;
#(
  parameter int unsigned SETUP_CYC = SETUP_DIAG_CYC,
  parameter int unsigned PHASE_CYC = SIG_PHASE_CYC,
  parameter int unsigned TAIL_CYC = SIG_TAIL_CYC,
  parameter int unsigned SETTLE_CYC = DRV_SETTLE_CYC,
  parameter int unsigned WATCHDOG_CYC = WDT_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Nonvolatile memory
  output logic nv_req,
  output logic nv_we,
  output logic [7:0] nv_addr,
  output logic [7:0] nv_wdata,
  input wire logic nv_ack,
  input wire logic [7:0] nv_rdata,
  // Output driver and its feedback
  output logic out_on,
  input wire logic fb_valid,
  input wire logic [FB_W-1:0] fb_sample,
  // Optical front end
  output logic sens_req,
  output logic [7:0] sens_gain,
  input wire logic sens_valid,
  input wire logic [7:0] sens_level,
  input wire logic det_mark,
  // Supervision and status
  input wire logic wdt_kick,
  output logic op_mode,
  output logic halted,
  output logic [2:0] fail_flags
);

  logic [1:0] rst_sync_q;
  logic rst_n;
  bds_state_e state_q;
  logic [1:0] step_q;
  logic [7:0] addr_q;
  logic [7:0] crc_q;
  logic [7:0] gain_q;
  logic [7:0] prev_q;
  logic [2:0] fail_q;
  logic out_on_q;
  logic op_mode_q;
  logic [7:0] sens_gain_q;
  logic [TMR_W-1:0] boot_cnt_q;
  logic [TMR_W-1:0] tmr_q;
  logic [TMR_W-1:0] tmr_lim;
  logic [TMR_W-1:0] wdt_q;
  logic setup_done;
  logic tmr_run;
  logic tmr_hit;
  logic wdt_expire;
  logic diag_busy;
  logic avg_start;
  logic avg_done;
  logic [FB_W-1:0] avg_mean;
  logic drv_ok;

  // ==========================================================
  // Reset release
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ==========================================================
  // Setup and diagnostic interval
  // 600 ms nominal count
  assign setup_done = (boot_cnt_q == TMR_W'(SETUP_CYC - 1));
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_cnt_q <= '0;
    end else if (state_q == ST_RESTART) begin
      boot_cnt_q <= '0;
    end else if (!setup_done) begin
      boot_cnt_q <= boot_cnt_q + 1'b1;
    end
  end

  // ==========================================================
  // Phase timer
  // per-phase terminal counts
  always_comb begin
    if (state_q == ST_DRV_SETTLE) begin
      tmr_lim = TMR_W'(SETTLE_CYC - 1);
    end else if (step_q == 2'(SIG_PHASES - 1)) begin
      tmr_lim = TMR_W'(TAIL_CYC - 1);
    end else begin
      tmr_lim = TMR_W'(PHASE_CYC - 1);
    end
  end
  assign tmr_run = (state_q == ST_DRV_SETTLE) || (state_q == ST_SIG);
  assign tmr_hit = tmr_run && (tmr_q == tmr_lim);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_q <= '0;
    end else if (!tmr_run || tmr_hit) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_q + 1'b1;
    end
  end

  // ==========================================================
  // Watchdog
  // stall in operation restarts
  assign wdt_expire = (state_q == ST_OPER) && (wdt_q == TMR_W'(WATCHDOG_CYC - 1));
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_q <= '0;
    end else if (state_q != ST_OPER || wdt_kick || wdt_expire) begin
      wdt_q <= '0;
    end else begin
      wdt_q <= wdt_q + 1'b1;
    end
  end

  // ==========================================================
  // Feedback averaging
  assign avg_start = (state_q == ST_DRV_SETTLE) && tmr_hit;
  bds_avg #(
    .W(FB_W),
    .LOG2(AVG_LOG2)
  ) u_avg (
    .clk(sys_clk),
    .rst_n(rst_n),
    .start(avg_start),
    .done(avg_done),
    .smp_valid(fb_valid),
    .smp(fb_sample),
    .mean(avg_mean)
  );
  assign drv_ok = (step_q == 2'd1) ? (avg_mean > FB_W'(FB_ON_CODE))
                                   : (avg_mean < FB_W'(FB_OFF_CODE));

  // ==========================================================
  // Sequencer
  assign diag_busy = (state_q == ST_RD) || (state_q == ST_DRV_SET) ||
                     (state_q == ST_DRV_SETTLE) || (state_q == ST_DRV_AVG) ||
                     (state_q == ST_SENS_SET) || (state_q == ST_SENS_WAIT);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_RESTART;
      step_q <= '0;
      addr_q <= NV_ADDR_GAIN;
      crc_q <= CRC_INIT;
      gain_q <= '0;
      prev_q <= '0;
      fail_q <= '0;
      out_on_q <= 1'b0;
      op_mode_q <= 1'b0;
      sens_gain_q <= '0;
    end else if (diag_busy && setup_done) begin
      // Checks overran the interval: treat as logic failure
      fail_q[FAIL_LOGIC] <= 1'b1;
      out_on_q <= 1'b0;
      step_q <= '0;
      state_q <= ST_FAIL_WR;
    end else begin
      unique case (state_q)
        ST_RESTART: begin
          fail_q <= '0;
          crc_q <= CRC_INIT;
          addr_q <= NV_ADDR_GAIN;
          out_on_q <= 1'b0;
          op_mode_q <= 1'b0;
          state_q <= ST_RD;
        end
        ST_RD: begin
          if (nv_ack) begin
            if (addr_q == NV_ADDR_CRC) begin
              if (nv_rdata != crc_q) begin
                fail_q[FAIL_LOGIC] <= 1'b1;
              end
              step_q <= '0;
              state_q <= ST_DRV_SET;
            end else begin
              crc_q <= bds_crc8(crc_q, nv_rdata);
              if (addr_q == NV_ADDR_GAIN) begin
                gain_q <= nv_rdata;
              end
              addr_q <= addr_q + 8'h01;
            end
          end
        end
        ST_DRV_SET: begin
          out_on_q <= (step_q == 2'd1);
          state_q <= ST_DRV_SETTLE;
        end
        ST_DRV_SETTLE: begin
          if (tmr_hit) begin
            state_q <= ST_DRV_AVG;
          end
        end
        ST_DRV_AVG: begin
          if (avg_done) begin
            if (!drv_ok) begin
              fail_q[FAIL_OUT] <= 1'b1;
            end
            if (step_q == 2'(DRV_STEPS - 1)) begin
              step_q <= '0;
              prev_q <= '0;
              state_q <= ST_SENS_SET;
            end else begin
              step_q <= step_q + 1'b1;
              state_q <= ST_DRV_SET;
            end
          end
        end
        ST_SENS_SET: begin
          sens_gain_q <= gain_q >> (2'(SENS_STEPS - 1) - step_q);
          state_q <= ST_SENS_WAIT;
        end
        ST_SENS_WAIT: begin
          if (sens_valid) begin
            if (sens_level <= prev_q) begin
              fail_q[FAIL_SENS] <= 1'b1;
            end
            prev_q <= sens_level;
            if (step_q == 2'(SENS_STEPS - 1)) begin
              state_q <= ST_CHECK;
            end else begin
              step_q <= step_q + 1'b1;
              state_q <= ST_SENS_SET;
            end
          end
        end
        ST_CHECK: begin
          out_on_q <= 1'b0;
          step_q <= '0;
          state_q <= (fail_q != 3'b000) ? ST_FAIL_WR : ST_SETUP_WAIT;
        end
        ST_SETUP_WAIT: begin
          if (setup_done) begin
            out_on_q <= 1'b1;
            step_q <= '0;
            state_q <= ST_SIG;
          end
        end
        ST_SIG: begin
          if (tmr_hit) begin
            if (step_q == 2'(SIG_PHASES - 1)) begin
              op_mode_q <= 1'b1;
              out_on_q <= det_mark;
              state_q <= ST_OPER;
            end else begin
              out_on_q <= step_q[0];
              step_q <= step_q + 1'b1;
            end
          end
        end
        ST_OPER: begin
          out_on_q <= det_mark;
          if (wdt_expire) begin
            state_q <= ST_RESTART;
          end
        end
        ST_FAIL_WR: begin
          out_on_q <= 1'b0;
          if (!fail_q[step_q] || nv_ack) begin
            if (step_q == 2'd2) begin
              state_q <= ST_HALT;
            end else begin
              step_q <= step_q + 1'b1;
            end
          end
        end
        ST_HALT: begin
          out_on_q <= 1'b0;
        end
        default: begin
          state_q <= ST_RESTART;
        end
      endcase
    end
  end

  // ==========================================================
  // Outputs
  assign nv_req = (state_q == ST_RD) || ((state_q == ST_FAIL_WR) && fail_q[step_q]);
  assign nv_we = (state_q == ST_FAIL_WR);
  assign nv_addr = (state_q == ST_FAIL_WR) ? (NV_ADDR_LOGIC_FAIL + {6'h00, step_q}) : addr_q;
  assign nv_wdata = FAIL_MARK;
  assign sens_req = (state_q == ST_SENS_WAIT);
  assign sens_gain = sens_gain_q;
  assign out_on = out_on_q;
  assign op_mode = op_mode_q;
  assign halted = (state_q == ST_HALT);
  assign fail_flags = fail_q;

endmodule : bds_top

`default_nettype wire

// [testbench/bds_checker.sv]
// Purpose: Port checks of the boot diagnostic sequencer
// Assumes: One clock domain, resetn active low
// Notes:   Bound to bds_top at the foot
`timescale 1ns/1ps
`default_nettype none
module bds_checker
  import bds_pkg::*;
#(
  parameter int unsigned SETUP_CYC = SETUP_DIAG_CYC,
  parameter int unsigned PHASE_CYC = SIG_PHASE_CYC,
  parameter int unsigned TAIL_CYC = SIG_TAIL_CYC,
  parameter int unsigned SETTLE_CYC = DRV_SETTLE_CYC,
  parameter int unsigned WATCHDOG_CYC = WDT_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Nonvolatile memory
  input wire logic nv_req,
  input wire logic nv_we,
  input wire logic [7:0] nv_addr,
  input wire logic [7:0] nv_wdata,
  input wire logic nv_ack,
  input wire logic [7:0] nv_rdata,
  // Driver and front end
  input wire logic out_on,
  input wire logic fb_valid,
  input wire logic [FB_W-1:0] fb_sample,
  input wire logic sens_req,
  input wire logic [7:0] sens_gain,
  input wire logic sens_valid,
  input wire logic [7:0] sens_level,
  input wire logic det_mark,
  // Supervision and status
  input wire logic wdt_kick,
  input wire logic op_mode,
  input wire logic halted,
  input wire logic [2:0] fail_flags
);
  // ==========
  // Run lengths of the output and of operation without a watchdog kick
  logic [31:0] lo_q;
  logic [31:0] run_q;
  logic [31:0] hi_q;
  logic [31:0] idle_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lo_q <= '0;
      run_q <= '0;
      hi_q <= '0;
    end else if (out_on) begin
      lo_q <= '0;
      run_q <= run_q + 32'h1;
    end else begin
      lo_q <= lo_q + 32'h1;
      run_q <= '0;
      if (run_q != '0) begin
        hi_q <= run_q;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      idle_q <= '0;
    end else if (op_mode && !wdt_kick) begin
      idle_q <= idle_q + 32'h1;
    end else begin
      idle_q <= '0;
    end
  end
  // ==========
  // Assertions
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_nv_wait;
    nv_req && !nv_ack;
  endsequence
  sequence s_op_enter;
    !op_mode ##1 op_mode;
  endsequence
  a_nv_hold: assert property (s_nv_wait |=> nv_req && $stable(nv_addr) && $stable(nv_we))
    else $error("nv request changed before ack");
  a_fail_write: assert property (nv_req && nv_we |->
    nv_wdata == FAIL_MARK && nv_addr >= NV_ADDR_LOGIC_FAIL && fail_flags != 3'h0)
    else $error("bad fail byte write");
  a_sig_tail: assert property (s_op_enter |-> lo_q inside {[TAIL_CYC-2:TAIL_CYC+2]})
    else $error("status tail length wrong");
  a_sig_phase: assert property (s_op_enter |-> hi_q inside {[PHASE_CYC-2:PHASE_CYC+2]})
    else $error("status on phase length wrong");
  a_fail_off: assert property (halted |-> !out_on && !op_mode)
    else $error("output active after failure");
  a_op_clean: assert property (op_mode |-> fail_flags == 3'h0)
    else $error("operation with failure flags");
  a_halt_hold: assert property (halted |=> halted && $stable(fail_flags))
    else $error("halt left without reset");
  a_op_follow: assert property (op_mode && $past(op_mode, 2) |-> out_on == $past(det_mark))
    else $error("output not following detection");
  a_wdt_bound: assert property (op_mode |-> idle_q <= WATCHDOG_CYC + 2)
    else $error("watchdog did not restart");
  a_sens_hold: assert property (sens_req && !sens_valid |=> sens_req && $stable(sens_gain))
    else $error("gain changed during request");
endmodule : bds_checker
bind bds_top bds_checker #(.SETUP_CYC(SETUP_CYC), .PHASE_CYC(PHASE_CYC), .TAIL_CYC(TAIL_CYC),
  .SETTLE_CYC(SETTLE_CYC), .WATCHDOG_CYC(WATCHDOG_CYC)) u_chk (
  .sys_clk(sys_clk), .resetn(resetn), .nv_req(nv_req), .nv_we(nv_we), .nv_addr(nv_addr),
  .nv_wdata(nv_wdata), .nv_ack(nv_ack), .nv_rdata(nv_rdata), .out_on(out_on),
  .fb_valid(fb_valid), .fb_sample(fb_sample), .sens_req(sens_req), .sens_gain(sens_gain),
  .sens_valid(sens_valid), .sens_level(sens_level), .det_mark(det_mark),
  .wdt_kick(wdt_kick), .op_mode(op_mode), .halted(halted), .fail_flags(fail_flags));
`default_nettype wire

// [testbench/bds_far_model.sv]
// Purpose: Memory, driver feedback and front end around the sequencer
// Assumes: Fault modes set before reset
// Notes:   Released lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module bds_far_model
  import bds_pkg::*;
(
  // Clock, reset and fault modes
  input wire logic clk,
  input wire logic rst_n,
  input wire logic crc_bad,
  input wire logic drv_bad,
  input wire logic sens_bad,
  // Nonvolatile memory
  input wire logic nv_req,
  input wire logic nv_we,
  input wire logic [7:0] nv_addr,
  input wire logic [7:0] nv_wdata,
  output logic nv_ack,
  output logic [7:0] nv_rdata,
  // Driver feedback
  input wire logic out_on,
  output logic fb_valid,
  output logic [FB_W-1:0] fb_sample,
  // Front end
  input wire logic sens_req,
  input wire logic [7:0] sens_gain,
  output logic sens_valid,
  output logic [7:0] sens_level
);
  logic [7:0] mem [256];
  logic [7:0] rd_q;
  logic [7:0] lv_q;
  logic [7:0] crc;
  logic [1:0] nv_w;
  logic [1:0] s_w;
  logic [FB_W-1:0] fb_q;
  // Map bytes apart from the checksum
  function automatic logic [7:0] img(input int a);
    if (a == 6) return 8'h40;
    if (a > 6 && a < 12) return 8'(8'h11 * (a - 6));
    return 8'h00;
  endfunction : img
  always @(posedge clk) begin
    if (!rst_n) begin
      crc = 8'h00;
      for (int i = 6; i < 12; i++) begin
        crc = crc ^ img(i);
        for (int b = 0; b < 8; b++) crc = crc[7] ? ((crc << 1) ^ 8'h07) : (crc << 1);
      end
      for (int i = 0; i < 256; i++) mem[i] <= (i == 12) ? (crc_bad ? ~crc : crc) : img(i);
      nv_ack <= 1'b0;
      nv_w <= 2'h0;
      s_w <= 2'h0;
      fb_valid <= 1'b0;
      sens_valid <= 1'b0;
    end else begin
      nv_ack <= 1'b0;
      if (nv_req && !nv_ack) begin
        nv_w <= nv_w + 2'h1;
        if (nv_w == 2'h2) begin
          nv_ack <= 1'b1;
          nv_w <= 2'h0;
          rd_q <= mem[nv_addr];
          if (nv_we) mem[nv_addr] <= nv_wdata;
        end
      end
      fb_valid <= !fb_valid;
      fb_q <= out_on ? (drv_bad ? 10'h064 : 10'h258) : 10'h00a;
      sens_valid <= 1'b0;
      if (sens_req && !sens_valid) begin
        s_w <= s_w + 2'h1;
        if (s_w == 2'h3) begin
          sens_valid <= 1'b1;
          lv_q <= sens_bad ? 8'h20 : sens_gain;
        end
      end
    end
  end
  assign nv_rdata = nv_ack ? rd_q : ~rd_q;
  assign fb_sample = fb_valid ? fb_q : ~fb_q;
  assign sens_level = sens_valid ? lv_q : ~lv_q;
endmodule : bds_far_model
`default_nettype wire

// [testbench/bds_top_bench.sv]
// Purpose: Self-checking bench of the boot diagnostic sequencer
// Assumes: Shortened phase counts
// Notes:   One pass boot with watchdog restart, then failure boots
`timescale 1ns/1ps
`default_nettype none
module bds_top_bench;
  import bds_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic wdt_kick = 1'b0;
  logic det_mark = 1'b0;
  logic crc_bad = 1'b0;
  logic drv_bad = 1'b0;
  logic sens_bad = 1'b0;
  logic nv_req, nv_we, nv_ack, out_on, fb_valid, sens_req, sens_valid, op_mode, halted;
  logic [7:0] nv_addr, nv_wdata, nv_rdata, sens_gain, sens_level;
  logic [FB_W-1:0] fb_sample;
  logic [2:0] fail_flags;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  always #2.5 sys_clk = ~sys_clk;
  bds_top #(.SETUP_CYC(2000), .PHASE_CYC(100), .TAIL_CYC(300), .SETTLE_CYC(10),
    .WATCHDOG_CYC(200)) DUT (.sys_clk(sys_clk), .resetn(resetn), .nv_req(nv_req),
    .nv_we(nv_we), .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_ack(nv_ack),
    .nv_rdata(nv_rdata), .out_on(out_on), .fb_valid(fb_valid), .fb_sample(fb_sample),
    .sens_req(sens_req), .sens_gain(sens_gain), .sens_valid(sens_valid),
    .sens_level(sens_level), .det_mark(det_mark), .wdt_kick(wdt_kick),
    .op_mode(op_mode), .halted(halted), .fail_flags(fail_flags));
  bds_far_model FAR (.clk(sys_clk), .rst_n(resetn), .crc_bad(crc_bad), .drv_bad(drv_bad),
    .sens_bad(sens_bad), .nv_req(nv_req), .nv_we(nv_we), .nv_addr(nv_addr),
    .nv_wdata(nv_wdata), .nv_ack(nv_ack), .nv_rdata(nv_rdata), .out_on(out_on),
    .fb_valid(fb_valid), .fb_sample(fb_sample), .sens_req(sens_req),
    .sens_gain(sens_gain), .sens_valid(sens_valid), .sens_level(sens_level));
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic boot(input logic c, input logic d, input logic s);
    @(posedge sys_clk);
    resetn <= 1'b0;
    crc_bad <= c;
    drv_bad <= d;
    sens_bad <= s;
    wdt_kick <= 1'b0;
    det_mark <= 1'b0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
  endtask : boot
  task automatic wait_sig(input bit sel_halt, input logic want, input int lim, output int n);
    n = 0;
    while (((sel_halt ? halted : op_mode) !== want) && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask : wait_sig
  task automatic t_pass;
    int n;
    boot(1'b0, 1'b0, 1'b0);
    wait_sig(1'b0, 1'b1, 4000, n);
    check("boot_len", 16'(n inside {[2595:2610]}), 16'h1);
    check("flags", {13'h0, fail_flags}, 16'h0);
    check("logic_byte", {8'h0, FAR.mem[8'hfd]}, 16'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      det_mark <= i[0];
      wdt_kick <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      check("follow", {15'h0, out_on}, {15'h0, i[0]});
    end
    @(posedge sys_clk);
    wdt_kick <= 1'b0;
    wait_sig(1'b0, 1'b0, 400, n);
    check("wdt_len", 16'(n inside {[196:206]}), 16'h1);
    check("wdt_out", {15'h0, out_on}, 16'h0);
    wait_sig(1'b0, 1'b1, 4000, n);
    check("reboot", 16'(n inside {[2590:2610]}), 16'h1);
  endtask : t_pass
  task automatic t_fail(input logic c, input logic d, input logic s, input logic [2:0] exp);
    int n;
    boot(c, d, s);
    wait_sig(1'b1, 1'b1, 4000, n);
    check("flags", {13'h0, fail_flags}, {13'h0, exp});
    check("out_off", {14'h0, out_on, op_mode}, 16'h0);
    for (int i = 0; i < 3; i++) begin
      check("fail_byte", {8'h0, FAR.mem[8'hfd + i]}, exp[i] ? {8'h0, FAIL_MARK} : 16'h0);
    end
    repeat (3000) @(posedge sys_clk);
    #1;
    check("still_halted", {14'h0, halted, op_mode}, 16'h2);
  endtask : t_fail
  initial begin
    t_pass();
    t_fail(1'b1, 1'b0, 1'b0, 3'h1);
    t_fail(1'b0, 1'b1, 1'b0, 3'h2);
    t_fail(1'b0, 1'b0, 1'b1, 3'h4);
    t_fail(1'b0, 1'b1, 1'b1, 3'h6);
    stop_test();
  end
endmodule : bds_top_bench
`default_nettype wire
